// [design/ast_pkg.sv]
package ast_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_NINTH = 3'b011,
    TX_STOP = 3'b100
  } ast_txst_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_NINTH = 3'b011,
    RX_STOP = 3'b100,
    RX_HOLD = 3'b101
  } ast_rxst_e;
endpackage

// [design/ast_regs.svh]
`ifndef AST_REGS_SVH
`define AST_REGS_SVH
// What this block does
// - rx data read with no data clears overrun
// - missing stop bit sets framing error
// - all-zero character sets break flag
// - holding empty flag; data write clears it
// - idle flag low while shifting out
// - status bit returns clear-to-send pin level
// - holding byte moves to shifter automatically
// - interrupt when holding register frees up
// - multiprocessor enable selects 9-bit frames
// - transmit only while transmit enable set
// - even/odd parity, only without multiprocessor mode
// - flow gate lets clear-to-send hold transmission
// - multiproc status resets zero, mixed access

// ***************************************
// register byte addresses
// ***************************************
`define AST_OFF_DATA 12'hF40
`define AST_OFF_MPSTAT 12'hF44
`define AST_OFF_LSTAT 12'hF48
`define AST_OFF_CTRL 12'hF4C
`define AST_OFF_BAUD 12'hF50
`define AST_OFF_ISTAT 12'hF54
`define AST_OFF_IMASK 12'hF58

// ***************************************
// field positions
// ***************************************
`define AST_CTRL_TXON 0
`define AST_CTRL_PAREN 1
`define AST_CTRL_PARODD 2
`define AST_CTRL_MULTIPROC_ENABLE 3
`define AST_CTRL_FLOW 4
`define AST_CTRL_MARK 5
`define AST_MP_RXMARK 0
`define AST_MP_SPARE 2
`define AST_MP_TWOSTOP 3
`define AST_INT_TXE 0
`define AST_INT_RXD 1
`define AST_INT_ERR 2

// ***************************************
// reset values and timing counts
// ***************************************
`define AST_CTRL_RST 6'h00
`define AST_MP_RST 2'h0
`define AST_BAUD_RST 16'h000D
`define AST_INT_RST 3'h0
`define AST_OVS_LAST 4'hF
`define AST_OVS_MID 4'h7
`endif

// [design/ast_rx.sv]
`timescale 1ns/1ns
`include "ast_regs.svh"
module ast_rx import ast_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic rxd,
  input wire logic ninth_en,
  output logic done,
  output logic [7:0] data,
  output logic ninth,
  output logic frame_err,
  output logic brk
);
  ast_rxst_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] sh_q, sh_d;
  logic nin_q, nin_d, done_q, done_d, fe_q, fe_d, brk_q, brk_d;

  // sample mid-bit; wait for idle line after a break
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    sh_d = sh_q;
    nin_d = nin_q;
    done_d = 1'b0;
    fe_d = fe_q;
    brk_d = brk_q;
    case (st_q)
      RX_IDLE: begin
        cnt_d = 4'h0;
        idx_d = 3'h0;
        nin_d = 1'b0;
        if (!rxd) begin
          st_d = RX_START;
        end
      end
      RX_HOLD: begin
        if (rxd) begin
          st_d = RX_IDLE;
        end
      end
      default: begin
        if (tick) begin
          cnt_d = cnt_q + 4'h1;
          if (st_q == RX_START && cnt_q == `AST_OVS_MID) begin
            cnt_d = 4'h0;
            st_d = rxd ? RX_IDLE : RX_DATA; // glitch rejected
          end else if (st_q != RX_START && cnt_q == `AST_OVS_LAST) begin
            if (st_q == RX_DATA) begin
              sh_d = {rxd, sh_q[7:1]};
              idx_d = idx_q + 3'h1;
              if (idx_q == 3'h7) begin
                st_d = ninth_en ? RX_NINTH : RX_STOP;
              end
            end else if (st_q == RX_NINTH) begin
              nin_d = rxd;
              st_d = RX_STOP;
            end else begin
              done_d = 1'b1;
              fe_d = ~rxd;
              brk_d = ~rxd & ~nin_q & (sh_q == 8'h00);
              st_d = rxd ? RX_IDLE : RX_HOLD;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= RX_IDLE;
      cnt_q <= 4'h0;
      idx_q <= 3'h0;
      sh_q <= 8'h00;
      nin_q <= 1'b0;
      done_q <= 1'b0;
      fe_q <= 1'b0;
      brk_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      sh_q <= sh_d;
      nin_q <= nin_d;
      done_q <= done_d;
      fe_q <= fe_d;
      brk_q <= brk_d;
    end
  end

  assign done = done_q;
  assign data = sh_q;
  assign ninth = nin_q;
  assign frame_err = fe_q;
  assign brk = brk_q;
endmodule

// [design/ast_tx.sv]
`timescale 1ns/1ns
`include "ast_regs.svh"
module ast_tx import ast_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic load,
  input wire logic [7:0] data,
  input wire logic ninth_en,
  input wire logic ninth_val,
  input wire logic two_stop,
  output logic txd,
  output logic busy
);
  ast_txst_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] sh_q, sh_d;
  logic nin_q, nin_d, stp_q, stp_d, txd_q, txd_d;

  // frame sequencer, sixteen ticks per bit
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    sh_d = sh_q;
    nin_d = nin_q;
    stp_d = stp_q;
    txd_d = txd_q;
    if (st_q == TX_IDLE) begin
      txd_d = 1'b1;
      cnt_d = 4'h0;
      if (load) begin
        sh_d = data;
        nin_d = ninth_val;
        stp_d = two_stop;
        idx_d = 3'h0;
        txd_d = 1'b0;
        st_d = TX_START;
      end
    end else if (tick) begin
      cnt_d = cnt_q + 4'h1;
      if (cnt_q == `AST_OVS_LAST) begin
        case (st_q)
          TX_START: begin
            txd_d = sh_q[0];
            st_d = TX_DATA;
          end
          TX_DATA: begin
            idx_d = idx_q + 3'h1;
            sh_d = {1'b0, sh_q[7:1]};
            if (idx_q == 3'h7) begin
              txd_d = ninth_en ? nin_q : 1'b1;
              st_d = ninth_en ? TX_NINTH : TX_STOP;
            end else begin
              txd_d = sh_q[1];
            end
          end
          TX_NINTH: begin
            txd_d = 1'b1;
            st_d = TX_STOP;
          end
          default: begin
            if (stp_q) begin
              stp_d = 1'b0;
            end else begin
              st_d = TX_IDLE;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= TX_IDLE;
      cnt_q <= 4'h0;
      idx_q <= 3'h0;
      sh_q <= 8'h00;
      nin_q <= 1'b0;
      stp_q <= 1'b0;
      txd_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      sh_q <= sh_d;
      nin_q <= nin_d;
      stp_q <= stp_d;
      txd_q <= txd_d;
    end
  end

  assign txd = txd_q;
  assign busy = (st_q != TX_IDLE);
endmodule

// [design/ast_uart.sv]
`timescale 1ns/1ns
`include "ast_regs.svh"
module ast_uart import ast_pkg::*; #(
  parameter int BAUD_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  input wire logic cts_n,
  output logic txd,
  output logic irq
);
  // ***************************************
  // elaboration check
  // ***************************************
  if (BAUD_W < 4 || BAUD_W > 16) begin : g_bad_w
    $error("ast_uart: BAUD_W must be 4..16");
  end

  // ***************************************
  // pin synchronisers
  // ***************************************
  logic rxd_m_q, rxd_s_q, cts_m_q, cts_s_q;
  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
      cts_m_q <= 1'b1;
      cts_s_q <= 1'b1;
    end else begin
      rxd_m_q <= rxd;
      rxd_s_q <= rxd_m_q;
      cts_m_q <= cts_n;
      cts_s_q <= cts_m_q;
    end
  end

  // ***************************************
  // state declarations
  // ***************************************
  logic [5:0] ctrl_q, ctrl_d;
  logic [1:0] mpctl_q, mpctl_d;
  logic [BAUD_W-1:0] baud_q, baud_d, bcnt_q, bcnt_d;
  logic tick_q, tick_d;
  logic [2:0] ist_q, ist_d, imask_q, imask_d;
  logic irq_q, irq_d;
  logic [7:0] hold_q, hold_d, rbuf_q, rbuf_d;
  logic full_q, full_d, hmark_q, hmark_d;
  logic rda_q, rda_d, ovr_q, ovr_d, fe_q, fe_d, brk_q, brk_d, perr_q, perr_d;
  logic rmark_q, rmark_d;
  logic [31:0] rdata_q, rdata_d;
  logic rdy_q, rdy_d, err_q, err_d;

  logic tx_busy, tx_load, tx_ninth, ninth_en, tx_line;
  logic rx_done, rx_ninth, rx_fe, rx_brk, rx_perr;
  logic [7:0] rx_data;
  logic acc, wr, rd, unmapped;
  logic [7:0] lstat;
  logic [31:0] rmux;

  // ***************************************
  // bit-rate divider
  // ***************************************
  // one-cycle tick at sixteen times the bit rate
  always_comb begin
    tick_d = 1'b0;
    bcnt_d = bcnt_q + BAUD_W'(1);
    if (bcnt_q >= baud_q) begin
      bcnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      bcnt_q <= bcnt_d;
      tick_q <= tick_d;
    end
  end

  // ***************************************
  // serial engines
  // ***************************************
  // multiprocessor mode wins over parity for the ninth bit
  assign ninth_en = ctrl_q[`AST_CTRL_MULTIPROC_ENABLE] | ctrl_q[`AST_CTRL_PAREN];
  assign tx_ninth = ctrl_q[`AST_CTRL_MULTIPROC_ENABLE] ? hmark_q :
                    (ctrl_q[`AST_CTRL_PARODD] ? ~^hold_q : ^hold_q);
  // hand over only when enabled and, if gated, clear-to-send is low
  assign tx_load = full_q & ~tx_busy & ctrl_q[`AST_CTRL_TXON] &
                   (~ctrl_q[`AST_CTRL_FLOW] | ~cts_s_q);
  assign rx_perr = ctrl_q[`AST_CTRL_PAREN] & ~ctrl_q[`AST_CTRL_MULTIPROC_ENABLE] &
                   (rx_ninth != (ctrl_q[`AST_CTRL_PARODD] ? ~^rx_data : ^rx_data));

  ast_tx u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_q),
    .load(tx_load),
    .data(hold_q),
    .ninth_en(ninth_en),
    .ninth_val(tx_ninth),
    .two_stop(mpctl_q[1]),
    .txd(tx_line),
    .busy(tx_busy)
  );

  ast_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_q),
    .rxd(rxd_s_q),
    .ninth_en(ninth_en),
    .done(rx_done),
    .data(rx_data),
    .ninth(rx_ninth),
    .frame_err(rx_fe),
    .brk(rx_brk)
  );

  // ***************************************
  // apb decode and read mux
  // ***************************************
  // two-cycle access: pready comes one cycle into the access phase
  assign acc = psel & penable & rdy_q;
  assign wr = acc & pwrite & ~err_q;
  assign rd = acc & ~pwrite & ~err_q;
  assign lstat = {rda_q, ovr_q, perr_q, fe_q, brk_q, ~full_q, ~tx_busy, cts_s_q};

  always_comb begin
    rmux = 32'h0000_0000;
    unmapped = 1'b0;
    if (paddr == `AST_OFF_DATA) begin
      rmux[7:0] = rbuf_q;
    end else if (paddr == `AST_OFF_MPSTAT) begin
      rmux[3:0] = {mpctl_q, 1'b0, rmark_q};
    end else if (paddr == `AST_OFF_LSTAT) begin
      rmux[7:0] = lstat;
    end else if (paddr == `AST_OFF_CTRL) begin
      rmux[5:0] = ctrl_q;
    end else if (paddr == `AST_OFF_BAUD) begin
      rmux[BAUD_W-1:0] = baud_q;
    end else if (paddr == `AST_OFF_ISTAT) begin
      rmux[2:0] = ist_q;
    end else if (paddr == `AST_OFF_IMASK) begin
      rmux[2:0] = imask_q;
    end else begin
      unmapped = 1'b1;
    end
  end

  // ***************************************
  // register file next state
  // ***************************************
  // clears first, hardware sets afterwards so an event is never lost
  always_comb begin
    rdy_d = psel & penable & ~rdy_q;
    rdata_d = rdata_q;
    // error flag lives only in the ready cycle, so pslverr is a bare flop
    err_d = 1'b0;
    if (psel & penable & ~rdy_q) begin
      rdata_d = pwrite ? 32'h0000_0000 : rmux;
      err_d = unmapped;
    end
    ctrl_d = ctrl_q;
    mpctl_d = mpctl_q;
    baud_d = baud_q;
    imask_d = imask_q;
    ist_d = ist_q;
    hold_d = hold_q;
    full_d = full_q;
    hmark_d = hmark_q;
    rbuf_d = rbuf_q;
    rda_d = rda_q;
    ovr_d = ovr_q;
    fe_d = fe_q;
    brk_d = brk_q;
    perr_d = perr_q;
    rmark_d = rmark_q;
    if (wr && paddr == `AST_OFF_CTRL) begin
      ctrl_d = pwdata[5:0];
    end
    if (wr && paddr == `AST_OFF_MPSTAT) begin
      mpctl_d = pwdata[`AST_MP_TWOSTOP:`AST_MP_SPARE];
    end
    if (wr && paddr == `AST_OFF_BAUD) begin
      baud_d = pwdata[BAUD_W-1:0];
    end
    if (wr && paddr == `AST_OFF_IMASK) begin
      imask_d = pwdata[2:0];
    end
    if (wr && paddr == `AST_OFF_ISTAT) begin
      ist_d = ist_q & ~pwdata[2:0];
    end
    if (tx_load) begin
      full_d = 1'b0;
    end
    if (wr && paddr == `AST_OFF_DATA) begin
      hold_d = pwdata[7:0];
      full_d = 1'b1;
      hmark_d = ctrl_q[`AST_CTRL_MARK];
    end
    if (rd && paddr == `AST_OFF_DATA) begin
      if (!rda_q) begin
        ovr_d = 1'b0;
      end
      rda_d = 1'b0;
      fe_d = 1'b0;
      brk_d = 1'b0;
      perr_d = 1'b0;
    end
    if (rx_done) begin
      rbuf_d = rx_data;
      rmark_d = ctrl_q[`AST_CTRL_MULTIPROC_ENABLE] & rx_ninth;
      if (rda_q && !(rd && paddr == `AST_OFF_DATA)) begin
        ovr_d = 1'b1;
      end
      rda_d = 1'b1;
      fe_d = fe_d | rx_fe;
      brk_d = brk_d | rx_brk;
      perr_d = perr_d | rx_perr;
    end
    ist_d[`AST_INT_TXE] = ist_d[`AST_INT_TXE] | tx_load;
    ist_d[`AST_INT_RXD] = ist_d[`AST_INT_RXD] | rx_done;
    ist_d[`AST_INT_ERR] = ist_d[`AST_INT_ERR] | (rx_done & (rx_fe | rx_brk | rx_perr | rda_q));
    irq_d = |(ist_d & imask_d);
  end

  // ***************************************
  // register file flops
  // ***************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= `AST_CTRL_RST;
      mpctl_q <= `AST_MP_RST;
      baud_q <= BAUD_W'(`AST_BAUD_RST);
      imask_q <= `AST_INT_RST;
      ist_q <= `AST_INT_RST;
      irq_q <= 1'b0;
      hold_q <= 8'h00;
      full_q <= 1'b0;
      hmark_q <= 1'b0;
      rbuf_q <= 8'h00;
      rda_q <= 1'b0;
      ovr_q <= 1'b0;
      fe_q <= 1'b0;
      brk_q <= 1'b0;
      perr_q <= 1'b0;
      rmark_q <= 1'b0;
    end else begin
      rdy_q <= rdy_d;
      err_q <= err_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      mpctl_q <= mpctl_d;
      baud_q <= baud_d;
      imask_q <= imask_d;
      ist_q <= ist_d;
      irq_q <= irq_d;
      hold_q <= hold_d;
      full_q <= full_d;
      hmark_q <= hmark_d;
      rbuf_q <= rbuf_d;
      rda_q <= rda_d;
      ovr_q <= ovr_d;
      fe_q <= fe_d;
      brk_q <= brk_d;
      perr_q <= perr_d;
      rmark_q <= rmark_d;
    end
  end

  // outputs straight from flops
  assign prdata = rdata_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign txd = tx_line;
  assign irq = irq_q;
endmodule

// [testbench/ast_remote.sv]
`timescale 1ns/1ns
module ast_remote (
  input wire logic pclk,
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  localparam int BITLEN = 16; // divisor 0: one tick a clock
  // line idle high, not clear to send
  initial begin
    rxd = 1'b1;
    cts_n = 1'b1;
  end
  task automatic bit_out(input logic b);
    rxd <= b;
    repeat (BITLEN) @(posedge pclk);
  endtask
  // a zero stop bit fakes framing and break faults
  task automatic send(input logic [8:0] v, input bit nine, input bit stop);
    @(posedge pclk);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) begin
      bit_out(v[i]);
    end
    if (nine) begin
      bit_out(v[8]);
    end
    bit_out(stop);
    bit_out(1'b1);
  endtask
  // unknown result on no frame or no stop bit
  task automatic get(output logic [8:0] v, input bit nine);
    int n;
    v = 'x;
    n = 0;
    // sample mid-cycle, clear of the edge that moves txd
    @(negedge pclk);
    while (txd !== 1'b0 && n < 4000) begin
      @(negedge pclk);
      n++;
    end
    if (n == 4000) begin
      @(posedge pclk);
      return;
    end
    repeat (BITLEN / 2) @(negedge pclk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (BITLEN) @(negedge pclk);
      v[i] = txd;
    end
    if (!nine) begin
      v[8] = 1'b0;
    end
    repeat (BITLEN) @(negedge pclk);
    if (txd !== 1'b1) begin
      v = 'x;
    end
    // let the stop bit run out so the sender is idle on return
    repeat (BITLEN / 2) @(posedge pclk);
  endtask
endmodule

// [testbench/ast_uart_monitor.sv]
`timescale 1ns/1ns
`include "ast_regs.svh"
module ast_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic txd,
  input wire logic irq
);
  logic [5:0] ctrl_q, ctrl_d;
  logic [2:0] mask_q, mask_d;
  logic hit, unm;
  // ****
  // shadow of control and mask
  // ****
  // writes land at the ack edge, as in the block
  always_comb begin
    hit = psel && penable && pready && pwrite;
    unm = paddr < `AST_OFF_DATA || paddr > `AST_OFF_IMASK || paddr[1:0] != 2'h0;
    ctrl_d = (hit && paddr == `AST_OFF_CTRL) ? pwdata[5:0] : ctrl_q;
    mask_d = (hit && paddr == `AST_OFF_IMASK) ? pwdata[2:0] : mask_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 6'h00;
      mask_q <= 3'h0;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
    end
  end
  // ****
  // properties
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ack_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  a_ack_once: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_map: assert property (pready |-> pslverr == unm)
    else $error("slave error wrong");
  a_wr_quiet: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on write");
  a_mp_ro: assert property (pready && !pwrite && paddr == `AST_OFF_MPSTAT |-> prdata[31:4] == 28'h0)
    else $error("reserved bits set");
  // the load decision sits one cycle before the seen fall, the pin two more
  a_tx_gate: assert property ($fell(txd) |-> $past(ctrl_q[0]))
    else $error("frame while off");
  a_flow_hold: assert property ($fell(txd) && $past(ctrl_q[4]) |-> !$past(cts_n, 3))
    else $error("frame while held off");
  a_start_bit: assert property ($fell(txd) |-> !txd [*8])
    else $error("start bit short");
  a_irq_mask: assert property (mask_q == 3'h0 [*2] |-> !irq)
    else $error("masked interrupt");
  c_frame: cover property ($fell(txd));
  c_irq: cover property (irq);
  c_err: cover property (pslverr);
endmodule

bind ast_uart ast_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxd(rxd), .cts_n(cts_n), .txd(txd), .irq(irq));

// [testbench/tb_async_serial_transceiver_status.sv]
`timescale 1ns/1ns
`include "ast_regs.svh"
module tb_async_serial_transceiver_status;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se, rxd, cts_n, txd, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [8:0] v;
  int err_total, samples_checked;
  logic [7:0] tc [5] = '{8'h29, 8'h09, 8'h03, 8'h07, 8'h0F};
  logic [7:0] td [5] = '{8'hA5, 8'h3C, 8'h07, 8'h07, 8'h03};
  logic [8:0] te [5] = '{9'h1A5, 9'h03C, 9'h107, 9'h007, 9'h003};
  ast_uart uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .cts_n(cts_n), .txd(txd), .irq(irq));
  ast_remote far (.pclk(pclk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ****
  // bus and compare tasks
  // ****
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // one idle cycle after each transfer keeps drivers single per step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // look mid-cycle, away from the edge that launches pready
    @(negedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(negedge pclk);
      n++;
    end
    r = prdata;
    se = pslverr;
    // request stands up to the edge that samples pready high
    @(posedge pclk);
    if (n == 50) begin
      err_total++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic rchk(input string s, input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    rd(a);
    chk(s, e, r & m);
  endtask
  // bounded poll of line status bits
  task automatic poll(input logic [31:0] m);
    r = 32'h0;
    for (int n = 0; (r & m) !== m; n++) begin
      if (n == 400) begin
        err_total++;
        close_out();
      end
      rd(`AST_OFF_LSTAT);
    end
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_total = 0;
    samples_checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("mpstat", `AST_OFF_MPSTAT, 32'h00, 32'hFFFFFFFF);
    rchk("lstat", `AST_OFF_LSTAT, 32'h07, 32'hFFFFFFFF);
    rchk("baud", `AST_OFF_BAUD, 32'h0D, 32'hFFFFFFFF);
    rd(12'hF5C);
    chk("slverr", 32'h1, {31'h0, se});
    wr(`AST_OFF_MPSTAT, 32'hFF);
    rchk("mpstat rw", `AST_OFF_MPSTAT, 32'h0C, 32'hFFFFFFFF);
    far.cts_n <= 1'b0;
    repeat (4) @(posedge pclk);
    rchk("cts", `AST_OFF_LSTAT, 32'h06, 32'hFF);
    wr(`AST_OFF_MPSTAT, 32'h00);
    wr(`AST_OFF_BAUD, 32'h0);
    wr(`AST_OFF_IMASK, 32'h1);
    wr(`AST_OFF_DATA, 32'h5A);
    repeat (40) @(posedge pclk);
    rchk("held", `AST_OFF_LSTAT, 32'h02, 32'hFF);
    chk("txd off", 32'h1, {31'h0, txd});
    fork
      far.get(v, 1'b0);
      begin
        wr(`AST_OFF_CTRL, 32'h01);
        rchk("busy", `AST_OFF_LSTAT, 32'h04, 32'h06);
      end
    join
    chk("tx byte", 32'h05A, {23'h0, v});
    rchk("done", `AST_OFF_LSTAT, 32'h06, 32'hFF);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`AST_OFF_ISTAT, 32'h1);
    wr(`AST_OFF_IMASK, 32'h0);
    chk("irq clr", 32'h0, {31'h0, irq});
    $display("test transmit done");
    foreach (tc[i]) begin
      poll(32'h2);
      wr(`AST_OFF_CTRL, {24'h0, tc[i]});
      poll(32'h4);
      fork
        far.get(v, tc[i][3] | tc[i][1]);
        wr(`AST_OFF_DATA, {24'h0, td[i]});
      join
      chk("frame", {23'h0, te[i]}, {23'h0, v});
    end
    $display("test frames done");
    far.cts_n <= 1'b1;
    wr(`AST_OFF_CTRL, 32'h11);
    fork
      far.get(v, 1'b0);
      begin
        wr(`AST_OFF_DATA, 32'h81);
        repeat (60) @(posedge pclk);
        chk("gated", 32'h1, {31'h0, txd});
        far.cts_n <= 1'b0;
      end
    join
    chk("flow frame", 32'h081, {23'h0, v});
    far.cts_n <= 1'b1;
    wr(`AST_OFF_CTRL, 32'h01);
    fork
      far.get(v, 1'b0);
      wr(`AST_OFF_DATA, 32'h66);
    join
    chk("ungated", 32'h066, {23'h0, v});
    $display("test flow done");
    wr(`AST_OFF_IMASK, 32'h6);
    far.send(9'h04B, 1'b0, 1'b1);
    rchk("rx stat", `AST_OFF_LSTAT, 32'h80, 32'hF8);
    rchk("rx data", `AST_OFF_DATA, 32'h4B, 32'hFF);
    far.send(9'h033, 1'b0, 1'b0);
    rchk("fe", `AST_OFF_LSTAT, 32'h10, 32'h18);
    chk("irq err", 32'h1, {31'h0, irq});
    rd(`AST_OFF_DATA);
    rchk("fe clr", `AST_OFF_LSTAT, 32'h00, 32'h18);
    far.send(9'h000, 1'b0, 1'b0);
    rchk("brk", `AST_OFF_LSTAT, 32'h08, 32'h08);
    rd(`AST_OFF_DATA);
    rchk("brk clr", `AST_OFF_LSTAT, 32'h00, 32'h18);
    far.send(9'h011, 1'b0, 1'b1);
    far.send(9'h022, 1'b0, 1'b1);
    rchk("ovr", `AST_OFF_LSTAT, 32'hC0, 32'hC0);
    rd(`AST_OFF_DATA);
    rchk("ovr kept", `AST_OFF_LSTAT, 32'h40, 32'hC0);
    rd(`AST_OFF_DATA);
    rchk("ovr clr", `AST_OFF_LSTAT, 32'h00, 32'hC0);
    wr(`AST_OFF_CTRL, 32'h09);
    far.send(9'h155, 1'b1, 1'b1);
    rchk("rx mark", `AST_OFF_MPSTAT, 32'h1, 32'h1);
    wr(`AST_OFF_ISTAT, 32'h7);
    rchk("istat", `AST_OFF_ISTAT, 32'h0, 32'h7);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("test receive done");
    close_out();
  end
endmodule
